// ### verilog/timer_hlt_pkg.sv
// Constants, types and mode decoding for the hardware limit timer mode controller
package timer_hlt_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int COUNT_W = 8;
  localparam int MODE_W = 5;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;
  localparam logic RUN_RESET = 1'h0;
  localparam logic PWM_RESET = 1'h0;
  localparam logic SYNC_RESET = 1'h0;

  // ----------------------------------------------------------------
  // Mode field encodings
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_SW_GATE = 5'h00;
  localparam logic [MODE_W-1:0] MODE_GATE_HIGH_STOP = 5'h01;
  localparam logic [MODE_W-1:0] MODE_GATE_LOW_STOP = 5'h02;
  localparam logic [MODE_W-1:0] MODE_LIMIT_ANY = 5'h03;
  localparam logic [MODE_W-1:0] MODE_LIMIT_RISE = 5'h04;
  localparam logic [MODE_W-1:0] MODE_LIMIT_FALL = 5'h05;
  localparam logic [MODE_W-1:0] MODE_LIMIT_LOW = 5'h06;
  localparam logic [MODE_W-1:0] MODE_LIMIT_HIGH = 5'h07;
  localparam logic [MODE_W-1:0] MODE_OS_SW = 5'h08;
  localparam logic [MODE_W-1:0] MODE_OS_RISE = 5'h09;
  localparam logic [MODE_W-1:0] MODE_OS_FALL = 5'h0a;
  localparam logic [MODE_W-1:0] MODE_OS_ANY = 5'h0b;
  localparam logic [MODE_W-1:0] MODE_OSL_RISE = 5'h0c;
  localparam logic [MODE_W-1:0] MODE_OSL_FALL = 5'h0d;
  localparam logic [MODE_W-1:0] MODE_OSLV_LOW = 5'h0e;
  localparam logic [MODE_W-1:0] MODE_OSLV_HIGH = 5'h0f;
  localparam logic [MODE_W-1:0] MODE_MONO_RISE = 5'h11;
  localparam logic [MODE_W-1:0] MODE_MONO_FALL = 5'h12;
  localparam logic [MODE_W-1:0] MODE_MONO_ANY = 5'h13;

  // Bit of the mode field that gives the reset level in level modes
  localparam int LEVEL_SEL_BIT = 0;

  typedef enum {
    CL_GATE, CL_EDGE_LIMIT, CL_LEVEL_LIMIT, CL_SW_ONESHOT, CL_EDGE_ONESHOT,
    CL_EDGE_LIMIT_OS, CL_LEVEL_OS, CL_MONO, CL_RESERVED
  } mode_class_t;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [COUNT_W-1:0] period;
    logic [COUNT_W-1:0] pulseWidth;
  } timer_cfg_t;

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic mode_class_t classOf(input logic [MODE_W-1:0] m);
    case (m)
      MODE_SW_GATE, MODE_GATE_HIGH_STOP, MODE_GATE_LOW_STOP: classOf = CL_GATE;
      MODE_LIMIT_ANY, MODE_LIMIT_RISE, MODE_LIMIT_FALL: classOf = CL_EDGE_LIMIT;
      MODE_LIMIT_LOW, MODE_LIMIT_HIGH: classOf = CL_LEVEL_LIMIT;
      MODE_OS_SW: classOf = CL_SW_ONESHOT;
      MODE_OS_RISE, MODE_OS_FALL, MODE_OS_ANY: classOf = CL_EDGE_ONESHOT;
      MODE_OSL_RISE, MODE_OSL_FALL: classOf = CL_EDGE_LIMIT_OS;
      MODE_OSLV_LOW, MODE_OSLV_HIGH: classOf = CL_LEVEL_OS;
      MODE_MONO_RISE, MODE_MONO_FALL, MODE_MONO_ANY: classOf = CL_MONO;
      default: classOf = CL_RESERVED;
    endcase
  endfunction

  function automatic logic edgeQualifies(input logic [MODE_W-1:0] m, input logic rise,
                                         input logic fall);
    case (m)
      MODE_LIMIT_RISE, MODE_OS_RISE, MODE_OSL_RISE, MODE_MONO_RISE: edgeQualifies = rise;
      MODE_LIMIT_FALL, MODE_OS_FALL, MODE_OSL_FALL, MODE_MONO_FALL: edgeQualifies = fall;
      MODE_LIMIT_ANY, MODE_OS_ANY, MODE_MONO_ANY: edgeQualifies = rise | fall;
      default: edgeQualifies = 1'b0;
    endcase
  endfunction

endpackage

// ### verilog/ext_signal_sync.sv
// Three-stage synchroniser with agreement filter for the external reset signal
module ext_signal_sync (
  input wire logic clk,   // Timer clock
  input wire logic rst,   // Asynchronous reset, active high
  input wire logic pinIn, // Raw external level
  output logic level      // Filtered, synchronised level
);
  import timer_hlt_pkg::*;

  logic s1, s2, s3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= SYNC_RESET;
      s2 <= SYNC_RESET;
      s3 <= SYNC_RESET;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change is taken only once the last two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= SYNC_RESET;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end

endmodule

// ### verilog/timer_hlt.sv
// Mode controller of an 8-bit period timer with hardware limit, one-shot and monostable modes
// Overview of operation
// - Gate modes stop counting at the blocking level
// - Gate modes otherwise count as software gate
// - Edge limit modes reset count on chosen edge
// - Early edge reset restarts the PWM pulse
// - Level limit modes hold count at reset level
// - Level limit modes ignore signal while stopped
// - Level limit resets at match or held level
// - Level limit restart raises PWM drive
// - PWM stays high through a level reset
// - Software one-shot clears run at period match
// - Run pause resumes; new cycle needs match
// - Software one-shot PWM from run set to compare
// - Edge one-shot starts on qualifying edge
// - Edge one-shot needs fresh edge after pause
// - Limit one-shot starts then edges reset count
// - Limit one-shot ignores edges until run set
// - Limit one-shot PWM on start and reset edges
// - Level one-shot holds reset, starts on release
// - Level one-shot clears run, needs new edge
// - Level one-shot PWM only on starting edge
// - Monostable starts on edge, halts at match
// - Monostable PWM only on starting edge
// - Monostable parks count at zero, run kept
// - Free-running modes wrap to zero after match
module timer_hlt (
  input wire logic clk,                        // Timer clock
  input wire logic rst,                        // Asynchronous reset, active high
  input wire logic runSet,                     // Software sets the run bit, one-cycle pulse
  input wire logic runClear,                   // Software clears the run bit, one-cycle pulse
  input wire timer_hlt_pkg::timer_cfg_t cfg,   // Mode, period and pulse-width compare
  input wire logic extResetPin,                // External reset signal, asynchronous
  output logic [timer_hlt_pkg::COUNT_W-1:0] countValue, // Timer count
  output logic runBit,                         // Run bit, cleared by hardware in one-shots
  output logic pwmDrive,                       // Drive to the compare PWM unit
  output logic periodMatch                     // Period match seen, one-cycle pulse
);
  import timer_hlt_pkg::*;

  // ----------------------------------------------------------------
  // External signal conditioning
  // ----------------------------------------------------------------
  logic ersLevel, ersPrev;

  ext_signal_sync uSync (
    .clk(clk),
    .rst(rst),
    .pinIn(extResetPin),
    .level(ersLevel)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ersPrev <= SYNC_RESET;
    end else begin
      ersPrev <= ersLevel;
    end
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  mode_class_t cls;
  logic rise, fall, edgeHit, levelReset, releaseEv, gateOpen, match;
  logic started;

  assign cls = classOf(cfg.mode);
  assign rise = ersLevel & ~ersPrev;
  assign fall = ~ersLevel & ersPrev;
  assign edgeHit = edgeQualifies(cfg.mode, rise, fall);
  assign levelReset = (ersLevel == cfg.mode[LEVEL_SEL_BIT]);
  assign releaseEv = (ersLevel != cfg.mode[LEVEL_SEL_BIT])
                     && (ersPrev == cfg.mode[LEVEL_SEL_BIT]);
  assign match = (countValue == cfg.period);

  always_comb begin
    case (cfg.mode)
      MODE_GATE_HIGH_STOP: gateOpen = ~ersLevel;
      MODE_GATE_LOW_STOP: gateOpen = ersLevel;
      default: gateOpen = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // Count sequencing
  // ----------------------------------------------------------------
  logic [COUNT_W-1:0] next_count;
  logic advance, restart, hwClear, startEv, cycleEnd, matchEv;

  always_comb begin
    next_count = countValue;
    advance = 1'b0;
    restart = 1'b0;
    hwClear = 1'b0;
    startEv = 1'b0;
    cycleEnd = 1'b0;
    matchEv = 1'b0;
    if (runBit) begin
      case (cls)
        CL_GATE: begin
          if (gateOpen) begin
            if (match) begin
              next_count = COUNT_RESET;
              restart = 1'b1;
              matchEv = 1'b1;
            end else begin
              next_count = countValue + COUNT_STEP;
              advance = 1'b1;
            end
          end
        end
        CL_EDGE_LIMIT: begin
          if (edgeHit) begin
            next_count = COUNT_RESET;
            restart = 1'b1;
          end else if (match) begin
            next_count = COUNT_RESET;
            restart = 1'b1;
            matchEv = 1'b1;
          end else begin
            next_count = countValue + COUNT_STEP;
            advance = 1'b1;
          end
        end
        CL_LEVEL_LIMIT: begin
          if (levelReset) begin
            next_count = COUNT_RESET;
          end else begin
            restart = releaseEv;
            if (match) begin
              next_count = COUNT_RESET;
              restart = 1'b1;
              matchEv = 1'b1;
            end else begin
              next_count = countValue + COUNT_STEP;
              advance = 1'b1;
            end
          end
        end
        CL_SW_ONESHOT: begin
          if (match) begin
            next_count = COUNT_RESET;
            hwClear = 1'b1;
            cycleEnd = 1'b1;
            matchEv = 1'b1;
          end else begin
            next_count = countValue + COUNT_STEP;
            advance = 1'b1;
          end
        end
        CL_EDGE_ONESHOT, CL_MONO: begin
          if (started) begin
            if (match) begin
              next_count = COUNT_RESET;
              hwClear = (cls == CL_EDGE_ONESHOT);
              cycleEnd = 1'b1;
              matchEv = 1'b1;
            end else begin
              next_count = countValue + COUNT_STEP;
              advance = 1'b1;
            end
          end else begin
            startEv = edgeHit;
          end
        end
        CL_EDGE_LIMIT_OS: begin
          if (started) begin
            if (edgeHit) begin
              next_count = COUNT_RESET;
              restart = 1'b1;
            end else if (match) begin
              next_count = COUNT_RESET;
              hwClear = 1'b1;
              cycleEnd = 1'b1;
              matchEv = 1'b1;
            end else begin
              next_count = countValue + COUNT_STEP;
              advance = 1'b1;
            end
          end else begin
            startEv = edgeHit;
          end
        end
        CL_LEVEL_OS: begin
          if (levelReset) begin
            next_count = COUNT_RESET;
          end else if (started) begin
            if (match) begin
              next_count = COUNT_RESET;
              hwClear = 1'b1;
              cycleEnd = 1'b1;
              matchEv = 1'b1;
            end else begin
              next_count = countValue + COUNT_STEP;
              advance = 1'b1;
            end
          end else begin
            startEv = releaseEv;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      countValue <= COUNT_RESET;
    end else begin
      countValue <= next_count;
    end
  end

  // ----------------------------------------------------------------
  // Run bit; a software set wins over a hardware clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      runBit <= RUN_RESET;
    end else if (runSet) begin
      runBit <= 1'b1;
    end else if (runClear || hwClear) begin
      runBit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Cycle tracking: armed-by-edge or software cycle in progress
  // ----------------------------------------------------------------
  logic swStart;

  assign swStart = (cls == CL_SW_ONESHOT) && runSet && (!started || cycleEnd);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      started <= 1'b0;
    end else if (cls == CL_SW_ONESHOT) begin
      if (swStart) begin
        started <= 1'b1;
      end else if (cycleEnd) begin
        started <= 1'b0;
      end
    end else if (!runBit || cycleEnd || (cls == CL_LEVEL_OS && levelReset)) begin
      started <= 1'b0;
    end else if (startEv) begin
      started <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // PWM drive and period match pulse
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwmDrive <= PWM_RESET;
    end else if (restart || startEv || swStart) begin
      pwmDrive <= 1'b1;
    end else if (advance && countValue == cfg.pulseWidth) begin
      pwmDrive <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periodMatch <= 1'b0;
    end else begin
      periodMatch <= matchEv;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pinHeld;
    extResetPin[*4];
  endsequence

  sequence s_edgeLimitHit;
    runBit && cls == CL_EDGE_LIMIT && edgeHit;
  endsequence

  sequence s_monoEnd;
    runBit && cls == CL_MONO && started && match;
  endsequence

  property p_gateStop;
    @(posedge clk) disable iff (rst)
    cfg.mode == MODE_GATE_HIGH_STOP && ersLevel && !runClear |=> $stable(countValue);
  endproperty
  a_gateStop: assert property (p_gateStop) else $error("gate did not stop count");

  property p_gateCount;
    @(posedge clk) disable iff (rst)
    cls == CL_GATE && runBit && gateOpen && !match |=> countValue == $past(countValue) + 8'h01;
  endproperty
  a_gateCount: assert property (p_gateCount) else $error("gate count did not step");

  property p_edgeReset;
    @(posedge clk) disable iff (rst)
    s_edgeLimitHit |=> countValue == 8'h00 && pwmDrive;
  endproperty
  a_edgeReset: assert property (p_edgeReset) else $error("edge reset missed");

  property p_edgeRestart;
    @(posedge clk) disable iff (rst)
    s_edgeLimitHit ##1 runBit && !edgeHit && cfg.period != 8'h00 |=> countValue == 8'h01;
  endproperty
  a_edgeRestart: assert property (p_edgeRestart) else $error("no restart after edge");

  property p_levelHold;
    @(posedge clk) disable iff (rst)
    runBit && cls == CL_LEVEL_LIMIT && levelReset |=> countValue == 8'h00;
  endproperty
  a_levelHold: assert property (p_levelHold) else $error("level reset not held");

  property p_levelIgnored;
    @(posedge clk) disable iff (rst)
    !runBit && cls == CL_LEVEL_LIMIT |=> $stable(countValue) && $stable(pwmDrive);
  endproperty
  a_levelIgnored: assert property (p_levelIgnored) else $error("stopped timer moved");

  property p_pwmHeldInReset;
    @(posedge clk) disable iff (rst)
    runBit && cls == CL_LEVEL_LIMIT && levelReset && pwmDrive |=> pwmDrive;
  endproperty
  a_pwmHeldInReset: assert property (p_pwmHeldInReset) else $error("pwm dropped in reset");

  property p_swOneShotEnd;
    @(posedge clk) disable iff (rst)
    runBit && cls == CL_SW_ONESHOT && match && !runSet |=> !runBit && countValue == 8'h00;
  endproperty
  a_swOneShotEnd: assert property (p_swOneShotEnd) else $error("one-shot did not end");

  property p_swPwmExtend;
    @(posedge clk) disable iff (rst)
    cls == CL_SW_ONESHOT && !runBit && !runSet && pwmDrive |=> pwmDrive;
  endproperty
  a_swPwmExtend: assert property (p_swPwmExtend) else $error("paused pwm dropped");

  property p_freshEdge;
    @(posedge clk) disable iff (rst)
    cls == CL_EDGE_ONESHOT && !runBit |=> !started;
  endproperty
  a_freshEdge: assert property (p_freshEdge) else $error("armed while stopped");

  property p_limitOsPwm;
    @(posedge clk) disable iff (rst)
    runBit && cls == CL_EDGE_LIMIT_OS && edgeHit
    |=> pwmDrive && (!$past(started) || countValue == 8'h00);
  endproperty
  a_limitOsPwm: assert property (p_limitOsPwm) else $error("limit one-shot edge missed");

  property p_levelOsNoReact;
    @(posedge clk) disable iff (rst)
    cls == CL_LEVEL_OS && matchEv && !pwmDrive |=> !pwmDrive;
  endproperty
  a_levelOsNoReact: assert property (p_levelOsNoReact) else $error("pwm raised at match");

  property p_monoPark;
    @(posedge clk) disable iff (rst)
    s_monoEnd ##0 !runClear |=> countValue == 8'h00 && runBit && !started ##1 $stable(countValue);
  endproperty
  a_monoPark: assert property (p_monoPark) else $error("monostable did not park");

  property p_syncLevel;
    @(posedge clk) disable iff (rst)
    s_pinHeld |=> ersLevel;
  endproperty
  a_syncLevel: assert property (p_syncLevel) else $error("sync level not taken");

endmodule

// ### sim/ers_partner.sv
// External reset signal source and compare unit stand-in for the timer bench
module ers_partner (
  input wire logic clk,     // Timer clock
  input wire logic rst,     // Reset, active high
  input wire logic toggleReq, // Ask for a level change
  input wire logic glitchReq, // Ask for a one-cycle pulse
  input wire logic pwmDrive,  // Drive from the timer
  output logic pinLevel,      // External reset signal
  output int pwmHighCycles    // Cycles seen with the drive high
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signal source, holds each level at least four cycles except the one-cycle level of a glitch pulse
  // ----------------------------------------------------------------
  int quiet;
  logic inGlitch;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinLevel <= 1'b0;
      quiet <= 0;
      inGlitch <= 1'b0;
      pwmHighCycles <= 0;
    end else begin
      if (pwmDrive) begin
        pwmHighCycles <= pwmHighCycles + 1;
      end
      if (inGlitch) begin
        pinLevel <= ~pinLevel;
        inGlitch <= 1'b0;
        quiet <= 0;
      end else if (quiet >= 4 && (toggleReq || glitchReq)) begin
        pinLevel <= ~pinLevel;
        inGlitch <= glitchReq & ~toggleReq;
        quiet <= 0;
      end else begin
        quiet <= quiet + 1;
      end
    end
  end
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the hardware limit timer mode controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_hlt_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic runSet = 1'b0;
  logic runClear = 1'b0;
  logic toggleReq = 1'b0;
  logic glitchReq = 1'b0;
  timer_cfg_t cfg = '0;
  logic pin;
  logic [COUNT_W-1:0] countValue;
  logic runBit, pwmDrive, periodMatch;
  int pwmHighCycles, n_mismatch, cmp_count, cycles, mPwmCycles, k, i, rv, per, mo;
  int seed = 32'h48a2;
  int mCnt, mRun, mPwm, mPm, mStarted, mFresh, m, pv, wv;
  logic s1, s2, s3, lvl, plvl, r, q, rlv, rel, step, hwClr, rise, fall;
  logic gate, elim, llim, sw, eos, elos, lvos, mono, noClear;

  always #50 clk = ~clk;

  timer_hlt DUT (.clk(clk), .rst(rst), .runSet(runSet), .runClear(runClear), .cfg(cfg),
    .extResetPin(pin), .countValue(countValue), .runBit(runBit), .pwmDrive(pwmDrive),
    .periodMatch(periodMatch));
  ers_partner partner (.clk(clk), .rst(rst), .toggleReq(toggleReq), .glitchReq(glitchReq),
    .pwmDrive(pwmDrive), .pinLevel(pin), .pwmHighCycles(pwmHighCycles));

  // ----------------------------------------------------------------
  // Reference model, one step per timer clock
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {mCnt, mRun, mPwm, mPm, mStarted, mFresh} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd1};
      {s1, s2, s3, lvl, plvl} = 5'h00;
    end else begin
      m = cfg.mode;
      pv = cfg.period;
      wv = cfg.pulseWidth;
      r = mRun[0];
      {mPm, step, hwClr} = 34'h0;
      gate = m <= 2;
      elim = m >= 3 && m <= 5;
      llim = m == 6 || m == 7;
      sw = m == 8;
      eos = m >= 9 && m <= 11;
      elos = m == 12 || m == 13;
      lvos = m == 14 || m == 15;
      mono = m >= 17 && m <= 19;
      rise = lvl & ~plvl;
      fall = ~lvl & plvl;
      q = (m == 4 || m == 9 || m == 12 || m == 17) ? rise :
          (m == 5 || m == 10 || m == 13 || m == 18) ? fall :
          (m == 3 || m == 11 || m == 19) ? (rise | fall) : 1'b0;
      rlv = (m == 6 || m == 14) ? ~lvl : lvl;
      rel = (m == 6 || m == 14) ? rise : fall;
      if (gate) begin
        step = r && !(m == 1 && lvl) && !(m == 2 && !lvl);
      end else if (elim) begin
        if (r && q) begin
          mCnt = 0;
          mPwm = 1;
        end else step = r;
      end else if (llim) begin
        if (r && rlv) mCnt = 0;
        else step = r;
      end else if (sw) begin
        step = r;
      end else if (eos || elos || mono) begin
        if (r && !mStarted && q) begin
          mStarted = 1;
          mPwm = 1;
        end else if (r && mStarted && elos && q) begin
          mCnt = 0;
          mPwm = 1;
        end else step = r && mStarted;
      end else if (lvos) begin
        if (rlv) begin
          mCnt = 0;
          mStarted = 0;
        end else if (r && !mStarted && rel) begin
          mStarted = 1;
          mPwm = 1;
        end else step = r && mStarted;
      end
      if (step) begin
        if (mCnt == pv) begin
          mCnt = 0;
          mPm = 1;
          if (gate || elim || llim) mPwm = 1;
          else if (mono) mStarted = 0;
          else begin
            hwClr = 1;
            mStarted = 0;
            mFresh = 1;
          end
        end else begin
          if (mCnt == wv) mPwm = 0;
          mCnt = mCnt + 1;
        end
      end
      // Starts and releases win over a compare drop in the same cycle
      if (llim && r && rel) mPwm = 1;
      if (sw && runSet && mFresh) begin
        mPwm = 1;
        mFresh = 0;
      end
      if (runSet) mRun = 1;
      else if (runClear || hwClr) mRun = 0;
      if (runClear && !runSet) mStarted = 0;
      plvl = lvl;
      if (s2 === s3) lvl = s3;
      s3 = s2;
      s2 = s1;
      s1 = pin;
    end
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input int exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(negedge clk) begin
    if (!rst) begin
      check("count", 32'(countValue), mCnt);
      check("run", 32'(runBit), mRun);
      check("pwm", 32'(pwmDrive), mPwm);
      check("match", 32'(periodMatch), mPm);
      if (mPwm == 1) mPwmCycles++;
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 6000) begin
      n_mismatch++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Every mode with random run control and signal activity
  // ----------------------------------------------------------------
  initial begin
    for (k = 0; k < 19; k++) begin
      @(posedge clk);
      rst <= 1'b1;
      mo = (k < 16) ? k : k + 1;
      noClear = mo == 14 || mo == 15;
      per = 3 + $unsigned($random(seed)) % 8;
      repeat (3) @(posedge clk);
      cfg <= '{mode: mo[4:0], period: per[7:0],
               pulseWidth: 8'(1 + $unsigned($random(seed)) % (per - 1))};
      rst <= 1'b0;
      mPwmCycles = 0;
      for (i = 0; i < 150; i++) begin
        @(posedge clk);
        rv = $unsigned($random(seed)) % 32;
        runSet <= (i == 1) || rv < 3;
        runClear <= (rv == 5) && !noClear;
        toggleReq <= rv >= 20;
        glitchReq <= rv == 7;
      end
      @(posedge clk);
      runSet <= 1'b0;
      runClear <= 1'b0;
      toggleReq <= 1'b0;
      glitchReq <= 1'b0;
      #1;
      check("pwm cycles", pwmHighCycles, mPwmCycles);
    end
    results();
  end
endmodule
